// ---- core/piopb_pkg.sv ----
// Purpose: Constants and types for the parallel I/O port bank.
// Assumes: Nine ports of up to 16 lines, AXI4-Lite register access.
// Notes: One state time is one i_clk_sys cycle.
// Overview of operation
// [R1] Ports 0 and 1 are two bytes each, port 2 has 16 lines, port 3 has 15 lines without line 14, ports 4, 6, 7 and 8 have 8 lines.
// [R2] Port 5 is sixteen input-only lines with no driver and no direction.
// [R3] Ports 2, 3, 4, 6, 7 and 8 select push-pull or open-drain per bit.
// [R4] An open-drain pin only drives low and otherwise lets the line go.
// [R5] Every pin level is sampled into its input latch each state time, in either direction.
// [R6] For an input pin a write goes only to the output latch and a read returns the sampled pin.
// [R7] For an input pin a read-modify-write reads the sampled pin and stores the result in the output latch.
// [R8] Direction 1 enables the driver, so a write reaches latch and pin and a read returns the latch.
// [R9] For an output pin a read-modify-write reads the latch and writes the latch, changing the pin.
// [R10] TTL or CMOS thresholds are chosen per byte, one bit for byte ports, two bits for ports 2, 3 and 5.
// [R11] The threshold choice never restricts direction or driver mode.
// [R12] After reset every pin is an input.
// [R13] An alternate output is ANDed with the port latch, except for PWM outputs.
// [R14] An output pin used as alternate input shows the output latch level.
// [R15] After reset drivers are push-pull and thresholds are TTL.
package piopb_pkg;

    localparam int NPORT = 9;
    localparam int PW    = 16;
    localparam int AW    = 12;

    typedef logic [NPORT-1:0][PW-1:0] piopb_bank_t;

    localparam logic [7:0]  OFS_PORT_STRIDE = 8'h10;
    localparam logic [3:0]  OFS_DATA        = 4'h0;
    localparam logic [3:0]  OFS_DIR         = 4'h4;
    localparam logic [3:0]  OFS_ODS         = 4'h8;
    localparam logic [3:0]  OFS_RMW         = 4'hC;
    localparam logic [AW-1:0] OFS_THR_MAIN  = 12'h100;
    localparam logic [AW-1:0] OFS_THR_EXT   = 12'h104;

    localparam int THR_MAIN_W = 8;
    localparam int THR_EXT_W  = 6;

    localparam logic [PW-1:0] RST_LATCH = 16'h0000;
    localparam logic [PW-1:0] RST_DIR   = 16'h0000;
    localparam logic [PW-1:0] RST_ODS   = 16'h0000;
    localparam logic [THR_MAIN_W-1:0] RST_THR_MAIN = 8'h00;
    localparam logic [THR_EXT_W-1:0]  RST_THR_EXT  = 6'h00;

    // Lines that exist, port 8 at the left
    localparam piopb_bank_t PORT_IMPL = {
        16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF,
        16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    localparam logic [NPORT-1:0] DIR_CAP = 9'h1DF;
    localparam logic [NPORT-1:0] OD_CAP  = 9'h1DC;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic          awvalid;
        logic [AW-1:0] awaddr;
        logic          wvalid;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bready;
        logic          arvalid;
        logic [AW-1:0] araddr;
        logic          rready;
    } piopb_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } piopb_axi_rsp_t;

endpackage

// ---- core/piopb_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to i_clk_sys.
// Notes: Output moves only where stages two and three agree.
`timescale 1ns/1ps
module piopb_sync #(
    parameter int W = 144
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Elaboration-time refusal of an empty pin vector
    if (W < 1) begin : g_bad_width
        $error("piopb_sync width must be positive");
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            s1  <= '0;
            s2  <= '0;
            s3  <= '0;
            o_q <= '0;
        end else begin
            s1  <= i_d;
            s2  <= s1;
            s3  <= s2;
            o_q <= (s2 & ~(s2 ^ s3)) | (o_q & (s2 ^ s3)); // [R5]
        end
    end

endmodule

// ---- core/piopb_top.sv ----
// Purpose: Parallel I/O port bank with AXI4-Lite registers.
// Assumes: Pins resolved outside from o_pin_out and o_pin_oe.
// Notes: Pin outputs lag register writes by one cycle.
`timescale 1ns/1ps
module piopb_top (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_sys_rst,
    input  wire piopb_pkg::piopb_axi_req_t i_axi,
    output piopb_pkg::piopb_axi_rsp_t  o_axi,
    input  wire piopb_pkg::piopb_bank_t i_pin_in,
    output piopb_pkg::piopb_bank_t     o_pin_out,
    output piopb_pkg::piopb_bank_t     o_pin_oe,
    input  wire piopb_pkg::piopb_bank_t i_alt_oe,
    input  wire piopb_pkg::piopb_bank_t i_alt_out,
    input  wire piopb_pkg::piopb_bank_t i_alt_pwm,
    output piopb_pkg::piopb_bank_t     o_alt_in,
    output logic [7:0]                 o_thr_main,
    output logic [5:0]                 o_thr_ext
);

    piopb_pkg::piopb_bank_t latch;
    piopb_pkg::piopb_bank_t dir;
    piopb_pkg::piopb_bank_t ods;
    piopb_pkg::piopb_bank_t in_lat;
    piopb_pkg::piopb_bank_t drive;

    logic [piopb_pkg::AW-1:0] awaddr_q;
    logic [31:0]              wdata_q;
    logic [3:0]               wstrb_q;
    logic                     wr_fire;
    logic                     ar_fire;
    logic                     w_ok;
    logic [3:0]               wport;
    logic [15:0]              rmw_mask;
    logic [15:0]              rmw_val;
    logic [31:0]              next_rdata;
    logic                     r_ok;

    // Value software sees when it reads a port
    function automatic logic [15:0] rd_view(
        input logic [15:0] d,
        input logic [15:0] l,
        input logic [15:0] p,
        input logic [15:0] m
    );
        rd_view = ((d & l) | (~d & p)) & m; // [R6] [R8]
    endfunction

    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [15:0] nw,
        input logic [1:0]  strb
    );
        merge = {strb[1] ? nw[15:8] : old[15:8],
                 strb[0] ? nw[7:0]  : old[7:0]};
    endfunction

    function automatic logic reg_ok(
        input logic [piopb_pkg::AW-1:0] a,
        input logic                     wr
    );
        logic [3:0] p;
        logic       hit;
        p   = a[7:4];
        hit = 1'b0;
        if (a == piopb_pkg::OFS_THR_MAIN) begin
            hit = 1'b1;
        end else if (a == piopb_pkg::OFS_THR_EXT) begin
            hit = 1'b1;
        end else if (a[11:8] == 4'h0 && p < 4'(piopb_pkg::NPORT)) begin
            case (a[3:0])
                piopb_pkg::OFS_DATA: begin
                    hit = !wr || piopb_pkg::DIR_CAP[p]; // [R2]
                end
                piopb_pkg::OFS_DIR: begin
                    hit = piopb_pkg::DIR_CAP[p];
                end
                piopb_pkg::OFS_ODS: begin
                    hit = piopb_pkg::OD_CAP[p]; // [R3]
                end
                piopb_pkg::OFS_RMW: begin
                    hit = piopb_pkg::DIR_CAP[p];
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
        reg_ok = hit;
    endfunction

    piopb_sync #(
        .W(piopb_pkg::NPORT * piopb_pkg::PW)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_d      (i_pin_in),
        .o_q      (in_lat)
    );

    // Bus handshakes; one write and one read outstanding
    assign wr_fire = !o_axi.awready && !o_axi.wready && !o_axi.bvalid;
    assign ar_fire = i_axi.arvalid && o_axi.arready;
    assign w_ok    = reg_ok(awaddr_q, 1'b1);
    assign wport   = w_ok ? awaddr_q[7:4] : 4'h0;
    assign r_ok    = reg_ok(i_axi.araddr, 1'b0);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_axi.awready <= 1'b1;
            o_axi.wready  <= 1'b1;
            o_axi.bvalid  <= 1'b0;
            o_axi.bresp   <= piopb_pkg::RESP_OKAY;
            o_axi.arready <= 1'b1;
            o_axi.rvalid  <= 1'b0;
            o_axi.rdata   <= 32'h0000_0000;
            o_axi.rresp   <= piopb_pkg::RESP_OKAY;
            awaddr_q      <= 12'h000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            if (i_axi.awvalid && o_axi.awready) begin
                o_axi.awready <= 1'b0;
                awaddr_q      <= i_axi.awaddr;
            end
            if (i_axi.wvalid && o_axi.wready) begin
                o_axi.wready <= 1'b0;
                wdata_q      <= i_axi.wdata;
                wstrb_q      <= i_axi.wstrb;
            end
            if (wr_fire) begin
                o_axi.bvalid <= 1'b1;
                o_axi.bresp  <= w_ok ? piopb_pkg::RESP_OKAY
                                     : piopb_pkg::RESP_SLVERR;
            end
            if (o_axi.bvalid && i_axi.bready) begin
                o_axi.bvalid  <= 1'b0;
                o_axi.awready <= 1'b1;
                o_axi.wready  <= 1'b1;
            end
            if (ar_fire) begin
                o_axi.arready <= 1'b0;
                o_axi.rvalid  <= 1'b1;
                o_axi.rdata   <= next_rdata;
                o_axi.rresp   <= r_ok ? piopb_pkg::RESP_OKAY
                                      : piopb_pkg::RESP_SLVERR;
            end
            if (o_axi.rvalid && i_axi.rready) begin
                o_axi.rvalid  <= 1'b0;
                o_axi.arready <= 1'b1;
            end
        end
    end

    always_comb begin
        logic [3:0] rp;
        rp         = i_axi.araddr[7:4];
        next_rdata = 32'h0000_0000;
        if (!r_ok) begin
            next_rdata = 32'h0000_0000;
        end else if (i_axi.araddr == piopb_pkg::OFS_THR_MAIN) begin
            next_rdata[7:0] = o_thr_main;
        end else if (i_axi.araddr == piopb_pkg::OFS_THR_EXT) begin
            next_rdata[5:0] = o_thr_ext;
        end else begin
            case (i_axi.araddr[3:0])
                piopb_pkg::OFS_DATA: begin
                    next_rdata[15:0] = rd_view(dir[rp], latch[rp],
                        in_lat[rp], piopb_pkg::PORT_IMPL[rp]); // [R6]
                end
                piopb_pkg::OFS_DIR: begin
                    next_rdata[15:0] = dir[rp];
                end
                piopb_pkg::OFS_ODS: begin
                    next_rdata[15:0] = ods[rp];
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // Upper half of the word selects bits, lower half gives them
    always_comb begin
        rmw_mask = wdata_q[31:16] & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}};
        rmw_val  = ((rd_view(dir[wport], latch[wport], in_lat[wport],
                     piopb_pkg::PORT_IMPL[wport]) & ~rmw_mask) |
                    (wdata_q[15:0] & rmw_mask)) &
                   piopb_pkg::PORT_IMPL[wport]; // [R7] [R9]
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            latch <= {piopb_pkg::NPORT{piopb_pkg::RST_LATCH}};
        end else if (wr_fire && w_ok) begin
            if (awaddr_q[3:0] == piopb_pkg::OFS_DATA &&
                awaddr_q[11:8] == 4'h0) begin
                // Latch written in either direction
                latch[wport] <= merge(latch[wport], wdata_q[15:0],
                    wstrb_q[1:0]) & piopb_pkg::PORT_IMPL[wport]; // [R6]
            end else if (awaddr_q[3:0] == piopb_pkg::OFS_RMW &&
                         awaddr_q[11:8] == 4'h0) begin
                latch[wport] <= rmw_val; // [R7] [R9]
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            dir <= {piopb_pkg::NPORT{piopb_pkg::RST_DIR}}; // [R12]
        end else if (wr_fire && w_ok && awaddr_q[11:8] == 4'h0 &&
                     awaddr_q[3:0] == piopb_pkg::OFS_DIR) begin
            dir[wport] <= merge(dir[wport], wdata_q[15:0],
                wstrb_q[1:0]) & piopb_pkg::PORT_IMPL[wport]; // [R1] [R2]
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ods <= {piopb_pkg::NPORT{piopb_pkg::RST_ODS}}; // [R15]
        end else if (wr_fire && w_ok && awaddr_q[11:8] == 4'h0 &&
                     awaddr_q[3:0] == piopb_pkg::OFS_ODS) begin
            ods[wport] <= merge(ods[wport], wdata_q[15:0],
                wstrb_q[1:0]) & piopb_pkg::PORT_IMPL[wport]; // [R3]
        end
    end

    // Threshold bits only go out to the pad cells
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_thr_main <= piopb_pkg::RST_THR_MAIN; // [R15]
            o_thr_ext  <= piopb_pkg::RST_THR_EXT;
        end else if (wr_fire && w_ok && wstrb_q[0]) begin
            if (awaddr_q == piopb_pkg::OFS_THR_MAIN) begin
                o_thr_main <= wdata_q[7:0]; // [R10]
            end
            if (awaddr_q == piopb_pkg::OFS_THR_EXT) begin
                o_thr_ext <= wdata_q[5:0]; // [R10]
            end
        end
    end

    // PWM bypasses the latch so its duty is not gated
    assign drive = (i_alt_oe & i_alt_out & (latch | i_alt_pwm)) |
                   (~i_alt_oe & latch); // [R13]

    // Driver depends on dir, ods and drive only, never on thresholds
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_pin_oe  <= '0;
            o_pin_out <= '0;
            o_alt_in  <= '0;
        end else begin
            o_pin_oe  <= dir & ~(ods & drive); // [R4] [R8] [R11]
            o_pin_out <= drive & ~ods & piopb_pkg::PORT_IMPL; // [R4]
            o_alt_in  <= (dir & latch) | (~dir & in_lat); // [R14]
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    dir_reset_a: assert property ( // [R12]
        $past(i_sys_rst) |-> (dir == '0 && o_pin_oe == '0))
        else $error("direction not input after reset");

    mode_reset_a: assert property ( // [R15]
        $past(i_sys_rst) |-> (ods == '0 && o_thr_main == 8'h00))
        else $error("driver mode or threshold not reset");

    port5_noout_a: assert property ( // [R2]
        o_pin_oe[5] == 16'h0000 && dir[5] == 16'h0000)
        else $error("input-only port drives");

    absent_line_a: assert property ( // [R1]
        !o_pin_oe[3][14] && o_pin_oe[4][15:8] == 8'h00 &&
        o_pin_oe[8][15:8] == 8'h00)
        else $error("missing line drives");

    od_no_high_a: assert property ( // [R4]
        ##1 (o_pin_oe[2] & o_pin_out[2] & $past(ods[2])) == 16'h0000)
        else $error("open-drain pin drives high");

    od_drive_low_a: assert property ( // [R4]
        (dir[4][4] && ods[4][4] && !drive[4][4]) |=>
        (o_pin_oe[4][4] && !o_pin_out[4][4]))
        else $error("open-drain pin fails to pull low");

    out_follow_a: assert property ( // [R8]
        (i_alt_oe[6] == 16'h0000 && ods[6] == 16'h0000) |=>
        o_pin_out[6] == $past(latch[6] & piopb_pkg::PORT_IMPL[6]))
        else $error("output pin does not follow latch");

    in_sample_a: assert property ( // [R5]
        $stable(i_pin_in[2])[*4] |=> in_lat[2] == $past(i_pin_in[2]))
        else $error("input latch misses pin level");

    read_view_a: assert property ( // [R6]
        (ar_fire && i_axi.araddr == 12'h020) |=>
        o_axi.rdata[15:0] == $past(rd_view(dir[2], latch[2],
            in_lat[2], 16'hFFFF)))
        else $error("port read returns wrong source");

    alt_in_a: assert property ( // [R14]
        (dir[4] == 16'h00FF) |=> o_alt_in[4][7:0] == $past(latch[4][7:0]))
        else $error("alternate input not fed by latch");

    bresp_after_a: assert property (
        wr_fire |=> o_axi.bvalid ##0 (!o_axi.awready && !o_axi.wready))
        else $error("write answer missing");

    wr_release_a: assert property (
        (o_axi.bvalid && i_axi.bready) |=>
        (!o_axi.bvalid && o_axi.awready && o_axi.wready))
        else $error("write channels not reopened after answer");

    rd_release_a: assert property (
        (o_axi.rvalid && i_axi.rready) |=> (!o_axi.rvalid && o_axi.arready))
        else $error("read channel not reopened after answer");

    rd_refuse_a: assert property (
        (ar_fire && !r_ok) |=> (o_axi.rvalid &&
        o_axi.rdata == 32'h0000_0000 && o_axi.rresp == piopb_pkg::RESP_SLVERR))
        else $error("refused read not answered with error");

    wr_refuse_a: assert property ( // [R2]
        (wr_fire && !w_ok) |=> ($stable(latch) && $stable(dir) &&
        $stable(ods) && $stable(o_thr_main) && $stable(o_thr_ext)))
        else $error("refused write changed state");

    in_dir_oe_a: assert property ( // [R6]
        (dir[3] == 16'h0000) |=> (o_pin_oe[3] == 16'h0000))
        else $error("input pin drives");

    out_read_a: assert property ( // [R8]
        (ar_fire && i_axi.araddr == 12'h030 && dir[3] == 16'hBFFF) |=>
        (o_axi.rdata[15:0] == $past(latch[3])))
        else $error("output pin read does not return latch");

    wr_cover_c: cover property (wr_fire && w_ok);
    rd_cover_c: cover property (ar_fire ##1 o_axi.rvalid);
    rmw_cover_c: cover property (
        wr_fire && w_ok && awaddr_q[3:0] == piopb_pkg::OFS_RMW);
    od_cover_c: cover property (o_pin_oe[4] != 16'h0000 && ods[4] != '0);

endmodule

// ---- sim/piopb_pins.sv ----
// Purpose: Pins and outside circuitry facing the port bank.
// Assumes: Bench sets external drive and pull-ups per pin.
// Notes: The device driver wins over outside drive; no contention model.
`timescale 1ns/1ps
module piopb_pins (
    input  wire logic                   i_clk_sys,
    input  wire piopb_pkg::piopb_bank_t i_pin_out,
    input  wire piopb_pkg::piopb_bank_t i_pin_oe,
    input  wire piopb_pkg::piopb_bank_t i_ext_oe,
    input  wire piopb_pkg::piopb_bank_t i_ext_val,
    input  wire piopb_pkg::piopb_bank_t i_pull_up,
    output piopb_pkg::piopb_bank_t      o_pin_lvl
);
    logic flt = 1'b0;

    // Floating lines wander so that no test leans on a stale level
    always @(posedge i_clk_sys) begin
        flt <= ~flt;
    end

    always_comb begin
        for (int p = 0; p < piopb_pkg::NPORT; p++) begin
            for (int b = 0; b < piopb_pkg::PW; b++) begin
                o_pin_lvl[p][b] = i_pin_oe[p][b] ? i_pin_out[p][b] :
                                  i_ext_oe[p][b] ? i_ext_val[p][b] :
                                  i_pull_up[p][b] ? 1'b1 : flt ^ b[0];
            end
        end
    end
endmodule

// ---- sim/piopb_bench.sv ----
// Purpose: Self-checking bench for the port bank over AXI4-Lite.
// Assumes: Pins come from the pin model; alternate inputs from here.
// Notes: Fixed waits cover the one-cycle pin lag and input filter.
`timescale 1ns/1ps
module piopb_bench;
    localparam logic [1:0] OK  = piopb_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = piopb_pkg::RESP_SLVERR;
    localparam logic [3:0] DAT = piopb_pkg::OFS_DATA;
    localparam logic [3:0] DIR = piopb_pkg::OFS_DIR;
    localparam logic [3:0] ODS = piopb_pkg::OFS_ODS;
    localparam logic [3:0] RMW = piopb_pkg::OFS_RMW;
    localparam logic [11:0] THM = 12'h100;
    localparam logic [11:0] THE = 12'h104;
    localparam logic [15:0] IMPL [9] = '{16'hFFFF, 16'hFFFF, 16'hFFFF,
        16'hBFFF, 16'h00FF, 16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF};

    logic                      clk;
    logic                      rst;
    piopb_pkg::piopb_axi_req_t req;
    piopb_pkg::piopb_axi_rsp_t rsp;
    piopb_pkg::piopb_bank_t    pin_lvl, pin_out, pin_oe, alt_in;
    piopb_pkg::piopb_bank_t    ext_oe, ext_val, pull;
    piopb_pkg::piopb_bank_t    alt_oe, alt_out, alt_pwm;
    logic [7:0]                thr_main;
    logic [5:0]                thr_ext;
    int                        fails = 0;
    int                        n_checks = 0;
    int                        cyc = 0;

    piopb_top u_piopb_top (.i_clk_sys(clk), .i_sys_rst(rst), .i_axi(req),
        .o_axi(rsp), .i_pin_in(pin_lvl), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .i_alt_oe(alt_oe), .i_alt_out(alt_out),
        .i_alt_pwm(alt_pwm), .o_alt_in(alt_in), .o_thr_main(thr_main),
        .o_thr_ext(thr_ext));

    piopb_pins u_piopb_pins (.i_clk_sys(clk), .i_pin_out(pin_out),
        .i_pin_oe(pin_oe), .i_ext_oe(ext_oe), .i_ext_val(ext_val),
        .i_pull_up(pull), .o_pin_lvl(pin_lvl));

    always #12.5 clk = ~clk;

    task automatic complete_run();
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            fails++;
        end
    endtask

    function automatic logic [11:0] pa(input int p, input logic [3:0] o);
        return 12'(p * 16) | {8'h00, o};
    endfunction

    // Waits for the answer as long as it takes; only the hang guard ends it
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic got;
        logic [1:0] r;
        got = 1'b0;
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= s;
        req.bready  <= 1'b1;
        while (!got) begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            got = rsp.bvalid;
            r = rsp.bresp;
        end
        req.bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
        @(posedge clk);
        chk("bvalid_end", 32'h0, {31'h0, rsp.bvalid});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        logic got;
        logic [1:0] r;
        logic [31:0] v;
        got = 1'b0;
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        while (!got) begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            got = rsp.rvalid;
            r = rsp.rresp;
            v = rsp.rdata;
        end
        req.rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, r});
        chk("rdata", e, v);
        @(posedge clk);
        chk("rvalid_end", 32'h0, {31'h0, rsp.rvalid});
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        ext_oe = '0;
        ext_val = '0;
        pull = '0;
        alt_oe = '0;
        alt_out = '0;
        alt_pwm = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int p = 0; p < 9; p++) begin
            if (p != 5) rd(pa(p, DIR), 32'h0, OK);
            if (p > 1 && p != 5) rd(pa(p, ODS), 32'h0, OK);
        end
        rd(THM, 32'h0, OK);
        rd(THE, 32'h0, OK);
        chk("oe_any", 32'h0, {31'h0, |pin_oe});
        // CMOS on P4 among others, then drive modes still apply
        wr(THM, 32'h0000_00A5, 4'h1, OK);
        wr(THE, 32'h0000_002B, 4'h1, OK);
        rd(THM, 32'h0000_00A5, OK);
        rd(THE, 32'h0000_002B, OK);
        chk("thr_main", 32'h0000_00A5, {24'h0, thr_main});
        chk("thr_ext", 32'h0000_002B, {26'h0, thr_ext});
        for (int p = 0; p < 9; p++) begin
            wr(pa(p, DIR), 32'h0000_FFFF, 4'h3, p == 5 ? ERR : OK);
            if (p != 5) rd(pa(p, DIR), {16'h0, IMPL[p]}, OK);
        end
        repeat (2) @(posedge clk);
        for (int p = 0; p < 9; p++) begin
            chk("oe", p == 5 ? 32'h0 : {16'h0, IMPL[p]},
                {16'h0, pin_oe[p]});
        end
        wr(pa(5, DAT), 32'h0000_00FF, 4'h3, ERR);
        wr(pa(2, DIR), 32'h0, 4'h3, OK);
        ext_oe[2] <= 16'hFFFF;
        ext_val[2] <= 16'hA5C3;
        wr(pa(2, DAT), 32'h0000_1234, 4'h3, OK);
        repeat (6) @(posedge clk);
        rd(pa(2, DAT), 32'h0000_A5C3, OK);
        chk("oe2", 32'h0, {16'h0, pin_oe[2]});
        chk("alt_in2", 32'h0000_A5C3, {16'h0, alt_in[2]});
        ext_oe[2] <= '0;
        pull[2] <= 16'hFFFF;
        wr(pa(2, DIR), 32'h0000_FFFF, 4'h3, OK);
        repeat (2) @(posedge clk);
        rd(pa(2, DAT), 32'h0000_1234, OK);
        chk("pin2", 32'h0000_1234, {16'h0, pin_out[2]});
        wr(pa(3, DIR), 32'h0, 4'h3, OK);
        ext_oe[3] <= 16'hFFFF;
        ext_val[3] <= 16'h00F0;
        repeat (6) @(posedge clk);
        wr(pa(3, RMW), 32'h000F_0005, 4'hF, OK);
        ext_oe[3] <= '0;
        pull[3] <= 16'hFFFF;
        wr(pa(3, DIR), 32'h0000_FFFF, 4'h3, OK);
        rd(pa(3, DAT), 32'h0000_00F5, OK);
        wr(pa(3, RMW), 32'hFF00_1200, 4'hF, OK);
        repeat (2) @(posedge clk);
        rd(pa(3, DAT), 32'h0000_12F5, OK);
        chk("pin3", 32'h0000_12F5, {16'h0, pin_out[3]});
        wr(pa(4, DAT), 32'h0000_000F, 4'h1, OK);
        wr(pa(4, ODS), 32'h0000_00FF, 4'h1, OK);
        pull[4] <= 16'h00FF;
        repeat (2) @(posedge clk);
        chk("oe4", 32'h0000_00F0, {16'h0, pin_oe[4]});
        chk("out4", 32'h0, {16'h0, pin_out[4]});
        rd(pa(4, ODS), 32'h0000_00FF, OK);
        wr(pa(0, ODS), 32'h0000_00FF, 4'h1, ERR);
        wr(pa(6, DAT), 32'h0000_000F, 4'h1, OK);
        alt_oe[6] <= 16'h00FF;
        alt_out[6] <= 16'h003C;
        repeat (3) @(posedge clk);
        chk("alt_and", 32'h0000_000C, {16'h0, pin_out[6]});
        chk("alt_in6", 32'h0000_000F, {16'h0, alt_in[6]});
        alt_pwm[6] <= 16'h00F0;
        repeat (3) @(posedge clk);
        chk("alt_pwm", 32'h0000_003C, {16'h0, pin_out[6]});
        rd(12'h200, 32'h0, ERR);
        wr(12'h200, 32'h0000_0001, 4'hF, ERR);
        complete_run();
    end
endmodule
